// ---- core/dcs_settings.sv ----
// drive current and comm settings store with its side effects
// assumes a command port from a text parser on the same clock
// Function
// - accel/decel current held in 0.01 A steps, limit 5.00 or 2.00 A
// - accel/decel current readable, writable, retained, mirrored to data register 029
// - accel/decel current write refused when below present running current
// - fieldbus bit-rate code 0 to 7, 1 Mbps down to 12.5 kbps
// - bit-rate code readable, writable, retained, default 0
// - first variant: running write below idle also loads idle current
// - other variant: every accepted running write sets idle to half of it
// - running current readable, writable, retained, mirrored to data register 030
// - after last step wait idle delay 0.00 to 10.00 s, then idle current
// - in pulse and direction modes each step pulse restarts idle timer
// - 8-bit comm error word read at once, read only, not retained
// - error bits 0-3: parity, framing, noise, receive overrun
// - error bits 4-7: rx full, tx full, bad opcode, tx timeout
// - any comm error also shown in fault code and status indicators
`include "dcs_defines.svh"
module dcs_settings
    import dcs_pkg::*;
#(
    parameter int TICK_CYC = `DCS_TICK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // strap inputs, from the same clock domain
    input wire logic variant_half,
    input wire logic motor_small,
    // retained values loaded on restore
    input wire logic restore,
    input wire logic [15:0] nv_accel,
    input wire logic [15:0] nv_run,
    input wire logic [15:0] nv_idle,
    input wire logic [15:0] nv_delay,
    input wire logic [2:0] nv_rate,
    // command port
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [2:0] cmd_sel,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ack,
    output logic cmd_nak,
    output logic [15:0] cmd_rdata,
    // motion and comm events
    input wire logic step_pulse,
    input wire logic pd_mode,
    input wire logic move_done,
    input wire logic [7:0] comm_err_set,
    input wire logic comm_err_clr,
    // settings out
    output logic [15:0] accel_decel_current,
    output logic [15:0] running_current,
    output logic [15:0] standstill_current,
    output logic [15:0] idle_delay_time,
    output logic [2:0] fieldbus_bit_rate_code,
    output logic [15:0] applied_current,
    output logic nv_save,
    output logic [7:0] fault_code,
    output logic comm_led
);
    logic [15:0] accel_r, run_r, idle_r, delay_r;
    logic [2:0] rate_r;
    logic [7:0] comm_error_flags_r;
    logic ack_r, nak_r;
    logic [15:0] rdata_r;
    logic save_r;
    logic at_idle;
    logic [15:0] max_cur;
    logic ok;

    // decode of a write strobe for one parameter
    function automatic logic wr_hit(input logic [2:0] sel, input logic [2:0] par);
        return sel == par;
    endfunction

    //------------------------------------------------------------
    // range checks
    //------------------------------------------------------------
    assign max_cur = motor_small ? `DCS_MAX_CUR_LO : `DCS_MAX_CUR_HI;
    // the command parser only reaches the ranges it can encode; the rest is refused here
    always_comb begin
        ok = 1'b1;
        case (cmd_sel)
            `DCS_PAR_ACCEL: ok = (cmd_wdata <= max_cur) && (cmd_wdata >= run_r);
            `DCS_PAR_RUN: ok = (cmd_wdata <= max_cur);
            `DCS_PAR_IDLE: ok = (cmd_wdata <= run_r);
            `DCS_PAR_DELAY: ok = (cmd_wdata <= `DCS_DELAY_MAX);
            `DCS_PAR_RATE: ok = (cmd_wdata <= 16'(`DCS_RATE_MAX));
            `DCS_PAR_ERR: ok = 1'b0;
            default: ok = 1'b0;
        endcase
    end

    //------------------------------------------------------------
    // stored settings
    //------------------------------------------------------------
    // accel/decel current
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accel_r <= `DCS_CUR_RST;
        end else if (restore) begin
            accel_r <= nv_accel;
        end else if (cmd_wr && ok && wr_hit(cmd_sel, `DCS_PAR_ACCEL)) begin
            accel_r <= cmd_wdata;
        end
    end

    // running current
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= `DCS_CUR_RST;
        end else if (restore) begin
            run_r <= nv_run;
        end else if (cmd_wr && ok && wr_hit(cmd_sel, `DCS_PAR_RUN)) begin
            run_r <= cmd_wdata;
        end
    end

    // idle current, with the automatic update on a running write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_r <= `DCS_CUR_RST;
        end else if (restore) begin
            idle_r <= nv_idle;
        end else if (cmd_wr && ok && wr_hit(cmd_sel, `DCS_PAR_RUN)) begin
            if (variant_half) begin
                idle_r <= {1'b0, cmd_wdata[15:1]};
            end else if (cmd_wdata < idle_r) begin
                idle_r <= cmd_wdata;
            end
        end else if (cmd_wr && ok && wr_hit(cmd_sel, `DCS_PAR_IDLE)) begin
            idle_r <= cmd_wdata;
        end
    end

    // idle delay and bit-rate code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            delay_r <= `DCS_DELAY_RST;
            rate_r <= `DCS_RATE_RST;
        end else if (restore) begin
            delay_r <= nv_delay;
            rate_r <= nv_rate;
        end else if (cmd_wr && ok) begin
            if (wr_hit(cmd_sel, `DCS_PAR_DELAY)) begin
                delay_r <= cmd_wdata;
            end
            if (wr_hit(cmd_sel, `DCS_PAR_RATE)) begin
                rate_r <= cmd_wdata[2:0];
            end
        end
    end

    //------------------------------------------------------------
    // comm error word
    //------------------------------------------------------------
    // set wins over clear so no error is lost; not restored on power up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            comm_error_flags_r <= 8'h00;
        end else if (comm_err_clr) begin
            comm_error_flags_r <= comm_err_set;
        end else begin
            comm_error_flags_r <= comm_error_flags_r | comm_err_set;
        end
    end

    //------------------------------------------------------------
    // command answers
    //------------------------------------------------------------
    // one answer per request, one cycle after it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            nak_r <= 1'b0;
            rdata_r <= 16'h0;
            save_r <= 1'b0;
        end else begin
            ack_r <= (cmd_wr && ok) || cmd_rd;
            nak_r <= cmd_wr && !ok;
            save_r <= cmd_wr && ok;
            if (cmd_rd) begin
                case (cmd_sel)
                    `DCS_PAR_ACCEL: rdata_r <= accel_r;
                    `DCS_PAR_RUN: rdata_r <= run_r;
                    `DCS_PAR_IDLE: rdata_r <= idle_r;
                    `DCS_PAR_DELAY: rdata_r <= delay_r;
                    `DCS_PAR_RATE: rdata_r <= {13'h0, rate_r};
                    `DCS_PAR_ERR: rdata_r <= {8'h00, comm_error_flags_r};
                    default: rdata_r <= 16'h0;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // idle timer and outputs
    //------------------------------------------------------------
    // outside pulse mode only the end of a move starts the delay
    dcs_idle_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .step_evt((pd_mode && step_pulse) || move_done),
        .delay_ticks(delay_r),
        .at_idle(at_idle)
    );

    assign applied_current = at_idle ? idle_r : run_r;
    assign fault_code = (comm_error_flags_r != 8'h00) ? `DCS_FAULT_COMM : 8'h00;
    assign comm_led = (comm_error_flags_r != 8'h00);
    assign cmd_ack = ack_r;
    assign cmd_nak = nak_r;
    assign cmd_rdata = rdata_r;
    assign nv_save = save_r;
    assign accel_decel_current = accel_r;
    assign running_current = run_r;
    assign standstill_current = idle_r;
    assign idle_delay_time = delay_r;
    assign fieldbus_bit_rate_code = rate_r;
endmodule

// ---- shared/dcs_defines.svh ----
// constants for the drive current and comm settings store
// assumes inclusion from the package and the core files
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
// parameter identifiers on the command port
`define DCS_PAR_ACCEL 3'h0
`define DCS_PAR_RUN 3'h1
`define DCS_PAR_IDLE 3'h2
`define DCS_PAR_DELAY 3'h3
`define DCS_PAR_RATE 3'h4
`define DCS_PAR_ERR 3'h5
// currents in units of 0.01 A
`define DCS_AMP_RES 16'h0001
`define DCS_MAX_CUR_HI 16'h01f4
`define DCS_MAX_CUR_LO 16'h00c8
// delay in units of 0.01 s, 0.00 to 10.00
`define DCS_DELAY_MAX 16'h03e8
`define DCS_TICK_NS 10000000
`define DCS_CLK_NS 20
`define DCS_TICK_CYC (`DCS_TICK_NS / `DCS_CLK_NS)
// bit-rate code range and default
`define DCS_RATE_MAX 3'h7
`define DCS_RATE_RST 3'h0
// reset values of the stored settings
`define DCS_CUR_RST 16'h0000
`define DCS_DELAY_RST 16'h0000
// error word bit positions
`define DCS_ERR_PARITY 0
`define DCS_ERR_FRAME 1
`define DCS_ERR_NOISE 2
`define DCS_ERR_OVERRUN 3
`define DCS_ERR_RXFULL 4
`define DCS_ERR_TXFULL 5
`define DCS_ERR_OPCODE 6
`define DCS_ERR_TXTO 7
// fault code shown while any comm error is present
`define DCS_FAULT_COMM 8'h01
`endif

// ---- shared/dcs_pkg.sv ----
// types for the drive current and comm settings store
// assumes the defines header is on the include path
`include "dcs_defines.svh"
package dcs_pkg;
    // stepper variant that picks the idle-current update on a running write
    typedef enum logic {
        dcs_var_follow_t_min,
        dcs_var_half
    } dcs_variant_t;
    // idle timer states
    typedef enum logic [1:0] {
        dcs_st_idle,
        dcs_st_count,
        dcs_st_standstill
    } dcs_tstate_t;
endpackage

// ---- core/dcs_idle_timer.sv ----
// idle-current delay timer: counts delay in 10 ms ticks after the last step
// assumes step_evt is a one-cycle pulse already in the clk domain
`include "dcs_defines.svh"
module dcs_idle_timer
    import dcs_pkg::*;
#(
    parameter int TICK_CYC = `DCS_TICK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // step events and programmed delay
    input wire logic step_evt,
    input wire logic [15:0] delay_ticks,
    // select idle current
    output logic at_idle
);
    dcs_tstate_t state_r;
    logic [18:0] pre_r;
    logic [15:0] tick_cnt_r;
    logic tick;

    //------------------------------------------------------------
    // prescaler
    //------------------------------------------------------------
    // prescaler restarts on a step so each delay is whole from the pulse
    assign tick = (pre_r == 19'(TICK_CYC - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= 19'h0;
        end else if (step_evt || tick) begin
            pre_r <= 19'h0;
        end else begin
            pre_r <= pre_r + 19'h1;
        end
    end

    //------------------------------------------------------------
    // state machine
    //------------------------------------------------------------
    // a zero delay drops to idle on the cycle after the step ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= dcs_st_standstill;
            tick_cnt_r <= 16'h0;
        end else if (step_evt) begin
            state_r <= dcs_st_count;
            tick_cnt_r <= 16'h0;
        end else begin
            case (state_r)
                dcs_st_count: begin
                    if (tick_cnt_r >= delay_ticks) begin
                        state_r <= dcs_st_standstill;
                    end else if (tick) begin
                        tick_cnt_r <= tick_cnt_r + 16'h1;
                    end
                end
                dcs_st_standstill: state_r <= dcs_st_standstill;
                default: state_r <= dcs_st_standstill;
            endcase
        end
    end

    assign at_idle = (state_r == dcs_st_standstill);
endmodule

// ---- tb/dcs_settings_props.sv ----
// checker for the settings store: command answers and side effects
// assumes binding to dcs_settings, one clock, async active-high reset
`include "dcs_defines.svh"
module dcs_settings_props
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched inputs
    input wire logic variant_half,
    input wire logic motor_small,
    input wire logic restore,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [2:0] cmd_sel,
    input wire logic [15:0] cmd_wdata,
    input wire logic step_pulse,
    input wire logic pd_mode,
    input wire logic move_done,
    input wire logic [7:0] comm_err_set,
    // watched outputs
    input wire logic cmd_ack,
    input wire logic cmd_nak,
    input wire logic nv_save,
    input wire logic [15:0] accel_decel_current,
    input wire logic [15:0] running_current,
    input wire logic [15:0] standstill_current,
    input wire logic [15:0] idle_delay_time,
    input wire logic [15:0] applied_current,
    input wire logic [7:0] fault_code,
    input wire logic comm_led
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking sample_edge @(posedge clk); endclocking
    default disable iff (rst);
    // restore is kept out: it outranks writes
    sequence run_wr_s; cmd_wr && !restore && cmd_sel == `DCS_PAR_RUN; endsequence
    sequence acc_wr_s; cmd_wr && !restore && cmd_sel == `DCS_PAR_ACCEL; endsequence
    wr_answer_a: assert property (cmd_wr && !restore |=> cmd_ack != cmd_nak)
        else $error("write not answered by exactly one of ack and nak");
    rd_answer_a: assert property (cmd_rd |=> cmd_ack && !cmd_nak)
        else $error("read not acknowledged next cycle");
    no_answer_a: assert property (!cmd_wr && !cmd_rd |=> !cmd_ack && !cmd_nak)
        else $error("answer without request");
    nak_hold_a: assert property (cmd_nak && !$past(restore) |->
        $stable(accel_decel_current) && $stable(running_current)
        && $stable(standstill_current) && $stable(idle_delay_time))
        else $error("refused write changed a setting");
    save_pulse_a: assert property (cmd_wr ##1 cmd_ack |-> nv_save)
        else $error("accepted write not saved");
    // the limit strap may move on the cycle after the write, so take the one the write saw
    accel_range_a: assert property (acc_wr_s ##1 cmd_ack |->
        accel_decel_current >= running_current && accel_decel_current <=
        ($past(motor_small) ? `DCS_MAX_CUR_LO : `DCS_MAX_CUR_HI))
        else $error("accel current accepted out of range");
    half_idle_a: assert property (run_wr_s ##1 cmd_ack |->
        running_current == $past(cmd_wdata)
        && (!$past(variant_half) || standstill_current == running_current >> 1))
        else $error("idle not half of running");
    follow_idle_a: assert property (run_wr_s ##1 cmd_ack |->
        $past(variant_half) || standstill_current == ($past(cmd_wdata) <
        $past(standstill_current) ? $past(cmd_wdata) : $past(standstill_current)))
        else $error("idle did not follow lower running");
    step_restart_a: assert property ((pd_mode && step_pulse) || move_done |=>
        applied_current == running_current)
        else $error("running current not applied after step");
    fault_show_a: assert property (|comm_err_set |=>
        fault_code == `DCS_FAULT_COMM && comm_led)
        else $error("comm error not shown");
endmodule
bind dcs_settings dcs_settings_props props_u (
    .clk(clk), .rst(rst), .variant_half(variant_half), .motor_small(motor_small),
    .restore(restore), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .step_pulse(step_pulse), .pd_mode(pd_mode),
    .move_done(move_done), .comm_err_set(comm_err_set), .cmd_ack(cmd_ack),
    .cmd_nak(cmd_nak), .nv_save(nv_save), .accel_decel_current(accel_decel_current),
    .running_current(running_current), .standstill_current(standstill_current),
    .idle_delay_time(idle_delay_time), .applied_current(applied_current),
    .fault_code(fault_code), .comm_led(comm_led)
);

// ---- tb/dcs_host.sv ----
// host model: one-cycle write and read requests on the command port
// assumes the store answers exactly one cycle after the request edge
module dcs_host (
    // clock
    input wire logic clk,
    // command port
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [2:0] cmd_sel,
    output logic [15:0] cmd_wdata,
    input wire logic cmd_ack,
    input wire logic cmd_nak,
    input wire logic [15:0] cmd_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // lines not qualified by a strobe show 19'h05a5a before the first request, then inverted data, never a stale copy
    initial begin
        {cmd_wr, cmd_rd} = 2'h0;
        {cmd_sel, cmd_wdata} = 19'h05a5a;
    end
    task automatic req(input logic w, input logic [2:0] s, input logic [15:0] d,
        output logic a, output logic k, output logic [15:0] q);
        @(negedge clk);
        {cmd_sel, cmd_wdata} = {s, d};
        {cmd_wr, cmd_rd} = {w, !w};
        @(negedge clk);
        {a, k, q} = {cmd_ack, cmd_nak, cmd_rdata};
        {cmd_wr, cmd_rd} = 2'h0;
        {cmd_sel, cmd_wdata} = ~{s, d};
    endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the settings store, random and corner writes
// assumes dcs_host on the command port and the bound checker
`include "dcs_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------
    // signals and instances
    // -----------------------------
    logic clk = 0, rst = 1, variant_half = 0, motor_small = 0, restore = 0;
    logic step_pulse = 0, pd_mode = 0, move_done = 0, comm_err_clr = 0, cmd_ack, cmd_nak;
    logic cmd_wr, cmd_rd, nv_save, comm_led, a, k;
    logic [2:0] cmd_sel, fieldbus_bit_rate_code, nv_rate = 0, m_rate;
    logic [15:0] nv_accel = 0, nv_run = 0, nv_idle = 0, nv_delay = 0, cmd_wdata, cmd_rdata, g;
    logic [15:0] accel_decel_current, running_current, standstill_current, idle_delay_time;
    logic [15:0] applied_current, m_acc, m_run, m_idl, m_dly;
    logic [7:0] comm_err_set = 0, fault_code, m_err;
    int n_errors = 0, checked = 0;
    always #10 clk = ~clk;
    dcs_settings #(.TICK_CYC(4)) dut_u (
        .clk(clk), .rst(rst), .variant_half(variant_half), .motor_small(motor_small),
        .restore(restore), .nv_accel(nv_accel), .nv_run(nv_run), .nv_idle(nv_idle),
        .nv_delay(nv_delay), .nv_rate(nv_rate), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nak(cmd_nak),
        .cmd_rdata(cmd_rdata), .step_pulse(step_pulse), .pd_mode(pd_mode),
        .move_done(move_done), .comm_err_set(comm_err_set), .comm_err_clr(comm_err_clr),
        .accel_decel_current(accel_decel_current), .running_current(running_current),
        .standstill_current(standstill_current), .idle_delay_time(idle_delay_time),
        .fieldbus_bit_rate_code(fieldbus_bit_rate_code), .applied_current(applied_current),
        .nv_save(nv_save), .fault_code(fault_code), .comm_led(comm_led)
    );
    dcs_host host_u (
        .clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
        .cmd_ack(cmd_ack), .cmd_nak(cmd_nak), .cmd_rdata(cmd_rdata)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // acceptance worked out from the limits and the present model
    function automatic bit ok(input logic [2:0] s, input logic [15:0] d);
        logic [15:0] lim;
        lim = motor_small ? `DCS_MAX_CUR_LO : `DCS_MAX_CUR_HI;
        case (s)
            3'h0: return d <= lim && d >= m_run;
            3'h1: return d <= lim;
            3'h2: return d <= m_run;
            3'h3: return d <= `DCS_DELAY_MAX;
            3'h4: return d <= 16'h0007;
            default: return 1'b0;
        endcase
    endfunction
    task automatic cmp_all;
        chk(accel_decel_current, m_acc);
        chk(running_current, m_run);
        chk(standstill_current, m_idl);
        chk(idle_delay_time, m_dly);
        chk(16'(fieldbus_bit_rate_code), 16'(m_rate));
    endtask
    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        bit e;
        e = ok(s, d);
        host_u.req(1'b1, s, d, a, k, g);
        chk(16'({a, k}), e ? 16'h0002 : 16'h0001);
        if (e) begin
            case (s)
                3'h0: m_acc = d;
                3'h1: {m_run, m_idl} = {d, variant_half ? d >> 1 : (d < m_idl ? d : m_idl)};
                3'h2: m_idl = d;
                3'h3: m_dly = d;
                default: m_rate = d[2:0];
            endcase
        end
        cmp_all;
    endtask
    task automatic rd(input logic [2:0] s, input logic [15:0] e);
        host_u.req(1'b0, s, 16'h0000, a, k, g);
        chk(16'({a, k}), 16'h0002);
        chk(g, e);
    endtask
    task automatic rd_all;
        rd(3'h0, m_acc);
        rd(3'h1, m_run);
        rd(3'h2, m_idl);
        rd(3'h3, m_dly);
        rd(3'h4, 16'(m_rate));
        rd(3'h5, 16'(m_err));
    endtask
    // one pulse on a bench-driven strobe, launched off the falling edge
    task automatic pulse(ref logic p);
        @(negedge clk) p = 1;
        @(negedge clk) p = 0;
    endtask
    task automatic end_of_test;
        $display("n_errors=%0d checked=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog: the sequence needs a few hundred cycles
    initial begin
        #400us;
        n_errors++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'hc899));
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 0;
        {m_acc, m_run, m_idl, m_dly, m_rate, m_err} = '0;
        cmp_all;
        rd_all;
        variant_half = 1;
        wr(3'h1, 16'h012c);
        wr(3'h2, 16'h0064);
        wr(3'h0, 16'h012b);
        wr(3'h0, 16'h01f5);
        wr(3'h3, 16'h03e9);
        wr(3'h5, 16'h0001);
        for (int i = 0; i < 9; i++) wr(3'h4, 16'(i));
        variant_half = 0;
        wr(3'h1, 16'h0032);
        repeat (60) begin
            {motor_small, variant_half} = 2'($urandom);
            wr(3'($urandom_range(0, 7)), 16'($urandom_range(0, 1100)));
        end
        rd_all;
        for (int b = 0; b < 8; b++) begin
            m_err = 8'h01 << b;
            @(negedge clk) comm_err_set = m_err;
            @(negedge clk) comm_err_set = 0;
            chk(16'({fault_code, comm_led}), 16'({`DCS_FAULT_COMM, 1'b1}));
            rd(3'h5, 16'(m_err));
            pulse(comm_err_clr);
        end
        // an error that lands with the clear must survive it
        @(negedge clk) {comm_err_set, comm_err_clr} = {8'h80, 1'b1};
        @(negedge clk) {comm_err_set, comm_err_clr} = 9'h000;
        rd(3'h5, 16'h0080);
        pulse(comm_err_clr);
        m_err = 0;
        chk(16'(fault_code), 16'h0000);
        variant_half = 1;
        wr(3'h1, 16'h0064);
        wr(3'h3, 16'h0002);
        pd_mode = 1;
        repeat (4) begin
            pulse(step_pulse);
            repeat (5) @(negedge clk);
            chk(applied_current, m_run);
        end
        repeat (12) @(negedge clk);
        chk(applied_current, m_idl);
        pd_mode = 0;
        wr(3'h3, 16'h0000);
        pulse(move_done);
        chk(applied_current, m_run);
        repeat (3) @(negedge clk);
        chk(applied_current, m_idl);
        g = 16'($urandom_range(0, 200));
        {nv_accel, nv_run, nv_idle, nv_delay, nv_rate} = {g, g, g, g, g[2:0]};
        pulse(restore);
        {m_acc, m_run, m_idl, m_dly, m_rate} = {g, g, g, g, g[2:0]};
        cmp_all;
        rd_all;
        end_of_test;
    end
endmodule
